// ==== tb_tmr16_core.sv ====
// Self-checking testbench of the 16-bit timer control core.
`define CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb_tmr16_core
  import tmr16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock;
  logic       arst_n;
  tmr16_bus_s bus;
  logic [7:0] rdata;
  logic       capture_pin;
  logic       ext_count_pin;
  logic [2:0] cmp_pin;
  logic [2:0] cmp_en;
  logic       ovf;
  logic       capf;
  logic [2:0] cmpf;
  int         errors;
  int         checks_done;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [1:0] acts [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
  logic       pins [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tmr16_core u_tmr16_core (.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .capture_pin(capture_pin), .ext_count_pin(ext_count_pin), .compare_output_pin(cmp_pin),
    .compare_output_en(cmp_en), .overflow_flag(ovf), .capture_flag(capf),
    .compare_flag(cmpf));
  tmr16_pin_model u_tmr16_pin_model (.clock(clock), .capture_pin(capture_pin),
    .ext_count_pin(ext_count_pin));

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // One byte write; the strobe drops one edge later so calls never collide.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask

  // Read data is registered, so it is sampled after the edge that takes the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    `CHECK(what, exp, d)
  endtask

  // Counter is written high byte first and read low byte first.
  task automatic set_count(input logic [15:0] v);
    wr(TMR16_IDX_CNT_HI, v[15:8]);
    wr(TMR16_IDX_CNT_LO, v[7:0]);
  endtask

  task automatic get_count(output logic [15:0] v);
    rd(TMR16_IDX_CNT_LO, lo);
    rd(TMR16_IDX_CNT_HI, hi);
    v = {hi, lo};
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    logic [15:0] c;
    int          n;
    clock = 1'b0;
    arst_n = 1'b0;
    bus = '0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(TMR16_IDX_CTRL_B, 8'h00, "ctrl_b reset");
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "flags reset");
    wr(TMR16_IDX_CTRL_B, 8'hE0);
    rd_chk(TMR16_IDX_CTRL_B, 8'hC0, "ctrl_b reserved");
    $display("test control done");
    // Forced matches in clear-on-match mode with compare A as top.
    set_count(16'h0055);
    wr(TMR16_IDX_CTRL_B, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(TMR16_IDX_CTRL_A, {acts[i], 6'h00});
      wr(TMR16_IDX_CTRL_C, 8'h80);
      repeat (2) @(posedge clock);
      `CHECK("force pin a", pins[i], cmp_pin[0])
      `CHECK("output enable a", 1'b1, cmp_en[0])
    end
    rd_chk(TMR16_IDX_CTRL_C, 8'h00, "force readback");
    get_count(c);
    `CHECK("count after force", 16'h0055, c)
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "flags after force");
    wr(TMR16_IDX_CTRL_B, 8'h00);
    wr(TMR16_IDX_CTRL_A, 8'hC1);
    wr(TMR16_IDX_CTRL_C, 8'h80);
    repeat (2) @(posedge clock);
    `CHECK("force in pwm", 1'b0, cmp_pin[0])
    wr(TMR16_IDX_CTRL_A, 8'h00);
    $display("test force done");
    set_count(16'h1234);
    repeat (50) @(posedge clock);
    `CHECK("output enables off", 3'h0, cmp_en)
    get_count(c);
    `CHECK("count stopped", 16'h1234, c)
    // Normal mode: a tick at the maximum wraps and flags, the next matches all at zero.
    set_count(16'hFFFF);
    wr(TMR16_IDX_CTRL_B, 8'h01);
    wr(TMR16_IDX_CTRL_B, 8'h00);
    rd_chk(TMR16_IDX_FLAGS, 8'h0F, "flags after wrap");
    `CHECK("overflow output", 1'b1, ovf)
    `CHECK("match outputs", 3'h7, cmpf)
    get_count(c);
    `CHECK("count after wrap", 16'h0001, c)
    wr(TMR16_IDX_FLAGS, 8'hFF);
    // Fast 8-bit PWM: two ticks from 0x00FE turn over at TOP and flag there.
    wr(TMR16_IDX_CTRL_A, 8'h01);
    set_count(16'h00FE);
    wr(TMR16_IDX_CTRL_B, 8'h09);
    wr(TMR16_IDX_CTRL_B, 8'h00);
    rd_chk(TMR16_IDX_FLAGS, 8'h01, "fast pwm flags");
    get_count(c);
    `CHECK("fast pwm top", 16'h0000, c)
    wr(TMR16_IDX_FLAGS, 8'hFF);
    wr(TMR16_IDX_CTRL_A, 8'h00);
    $display("test counter access done");
    // Each prescaler tap runs for eight of its periods.
    for (int i = 1; i < 6; i++) begin
      n = (i == 1) ? 1 : (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
      set_count(16'h0000);
      wr(TMR16_IDX_CTRL_B, 8'(i));
      repeat (8 * n) @(posedge clock);
      wr(TMR16_IDX_CTRL_B, 8'h00);
      get_count(c);
      `CHECK("prescaled count", 1'b1, (c >= 16'h0007 && c <= 16'h000A))
    end
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "no match after write");
    $display("test prescaler done");
    for (int i = 6; i < 8; i++) begin
      set_count(16'h0000);
      wr(TMR16_IDX_CTRL_B, 8'(i));
      u_tmr16_pin_model.ext_pulses(5);
      repeat (10) @(posedge clock);
      wr(TMR16_IDX_CTRL_B, 8'h00);
      get_count(c);
      `CHECK("external count", 16'h0005, c)
    end
    $display("test external clock done");
    set_count(16'h0ABC);
    wr(TMR16_IDX_CTRL_B, 8'h40);
    u_tmr16_pin_model.cap_level(1'b1, 10);
    rd_chk(TMR16_IDX_FLAGS, 8'h20, "capture rising");
    `CHECK("capture flag output", 1'b1, capf)
    rd_chk(TMR16_IDX_CAP_LO, 8'hBC, "capture low");
    rd_chk(TMR16_IDX_CAP_HI, 8'h0A, "capture high");
    wr(TMR16_IDX_FLAGS, 8'hFF);
    u_tmr16_pin_model.cap_level(1'b0, 10);
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "no capture on fall");
    wr(TMR16_IDX_CTRL_B, 8'h00);
    u_tmr16_pin_model.cap_level(1'b1, 10);
    u_tmr16_pin_model.cap_level(1'b0, 10);
    rd_chk(TMR16_IDX_FLAGS, 8'h20, "capture falling");
    wr(TMR16_IDX_FLAGS, 8'hFF);
    wr(TMR16_IDX_CTRL_B, 8'hC0);
    u_tmr16_pin_model.cap_level(1'b1, 2);
    u_tmr16_pin_model.cap_level(1'b0, 12);
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "filtered glitch");
    u_tmr16_pin_model.cap_level(1'b1, 14);
    rd_chk(TMR16_IDX_FLAGS, 8'h20, "filtered edge");
    wr(TMR16_IDX_FLAGS, 8'hFF);
    wr(TMR16_IDX_CTRL_B, 8'h58);
    u_tmr16_pin_model.cap_level(1'b0, 10);
    u_tmr16_pin_model.cap_level(1'b1, 10);
    rd_chk(TMR16_IDX_FLAGS, 8'h00, "capture as top");
    $display("test capture done");
    wrap_up();
  end

  // A hang is cut off well beyond the roughly 12000 cycles the tests need.
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    wrap_up();
  end
endmodule

// ==== tmr16_core.sv ====
// One 16-bit timer/counter control core: mode decode, clocking, capture, force and counter access.
// Summary of operation
// - Four-bit wave mode from two bits each of control A and B; mode 13 reserved.
// - Mode 0 counts to 0xFFFF, compare writes immediate, overflow at maximum.
// - Fixed PWM tops 0x00FF/0x01FF/0x03FF; 1-3 phase correct, 5-7 fast.
// - Phase correct loads at TOP, flags at BOTTOM; fast PWM does both at TOP.
// - Mode 4 top is compare A, mode 12 capture; immediate update, flag at max.
// - Modes 8 and 9 top capture/compare A; load and flag at BOTTOM.
// - Filter enabled: capture input changes only after four equal samples.
// - Edge select 0 captures on falling edge, 1 on rising edge.
// - Capture copies counter to capture value and sets capture flag.
// - Capture pin disconnected while capture value serves as TOP.
// - Clock select codes 0-5: stopped, divide by 1, 8, 64, 256, 1024.
// - Clock select zero stops the counter.
// - Codes 6 and 7 count falling or rising edges of the external pin.
// - External pin edges count even when the pin is driven as output.
// - Force bit write forces an immediate match using the output action.
// - Force bits act only in normal and clear-on-match modes.
// - Forced match raises no flag and never clears the counter.
// - Force bits are strobes and always read as zero.
// - Counter accessed as two bytes through a shared temporary high byte.
// - A counter write blocks compare matches on the next timer clock.
// - Non-PWM actions: 00 off, 01 toggle, 10 clear, 11 set on match.
module tmr16_core
  import tmr16_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire tmr16_bus_s bus,
  output logic [7:0]      rdata,
  input  wire logic       capture_pin,
  input  wire logic       ext_count_pin,
  output logic [2:0]      compare_output_pin,
  output logic [2:0]      compare_output_en,
  output logic            overflow_flag,
  output logic            capture_flag,
  output logic [2:0]      compare_flag
);
  // Counter and fixed tops are sixteen bits and the temporary holds their high byte, so other widths are refused.
  if (CNT_W != 16) begin
    $error("tmr16_core supports a 16-bit counter only");
  end

  logic [7:0]        timer_ctrl_a;
  logic [7:0]        timer_ctrl_b;
  logic [7:0]        temp_hi;
  logic [15:0]       count_value;
  logic [15:0]       capture_value;
  logic [15:0]       compare_value [3];
  logic [15:0]       compare_buf   [3];
  logic              count_down;
  logic              block_match;
  logic [9:0]        presc;
  logic              filt_out;
  logic [1:0]        filt_run;
  logic [2:0]        wave;
  logic [7:0]        rdata_q;
  logic [7:0]        next_ctrl_a, next_ctrl_b, next_temp, next_rdata;
  logic [15:0]       next_count, next_capture;
  logic [15:0]       next_cmp [3];
  logic [15:0]       next_buf [3];
  logic              next_down, next_block, next_filt_out;
  logic [1:0]        next_filt_run;
  logic [9:0]        next_presc;
  logic [2:0]        next_wave, next_cmpf;
  logic              next_ovf, next_icf;
  logic [3:0]        wave_mode_sel;
  tmr16_mode_s       md;
  tmr16_clk_e        clock_sel;
  logic              tick, cap_lvl, cap_rise, cap_fall, ext_rise, ext_fall;
  logic [15:0]       top;
  logic              cap_trig, at_top, at_bottom;
  logic [2:0]        force_str;

  // Waveform mode table; reserved mode 13 behaves as normal counting.
  function automatic tmr16_mode_s decode(input logic [3:0] m);
    tmr16_mode_s d;
    d = '{TMR16_TOP_FIX, TMR16_MAX, TMR16_AT_NOW, TMR16_AT_MAX, 1'b0, 1'b0};
    case (m)
      4'h1: d = '{TMR16_TOP_FIX, TMR16_TOP8, TMR16_AT_TOP, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'h2: d = '{TMR16_TOP_FIX, TMR16_TOP9, TMR16_AT_TOP, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'h3: d = '{TMR16_TOP_FIX, TMR16_TOP10, TMR16_AT_TOP, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'h4: d = '{TMR16_TOP_CMPA, TMR16_MAX, TMR16_AT_NOW, TMR16_AT_MAX, 1'b0, 1'b0};
      4'h5: d = '{TMR16_TOP_FIX, TMR16_TOP8, TMR16_AT_TOP, TMR16_AT_TOP, 1'b0, 1'b1};
      4'h6: d = '{TMR16_TOP_FIX, TMR16_TOP9, TMR16_AT_TOP, TMR16_AT_TOP, 1'b0, 1'b1};
      4'h7: d = '{TMR16_TOP_FIX, TMR16_TOP10, TMR16_AT_TOP, TMR16_AT_TOP, 1'b0, 1'b1};
      4'h8: d = '{TMR16_TOP_CAP, TMR16_MAX, TMR16_AT_BOTTOM, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'h9: d = '{TMR16_TOP_CMPA, TMR16_MAX, TMR16_AT_BOTTOM, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'hA: d = '{TMR16_TOP_CAP, TMR16_MAX, TMR16_AT_TOP, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'hB: d = '{TMR16_TOP_CMPA, TMR16_MAX, TMR16_AT_TOP, TMR16_AT_BOTTOM, 1'b1, 1'b1};
      4'hC: d = '{TMR16_TOP_CAP, TMR16_MAX, TMR16_AT_NOW, TMR16_AT_MAX, 1'b0, 1'b0};
      4'hE: d = '{TMR16_TOP_CAP, TMR16_MAX, TMR16_AT_TOP, TMR16_AT_TOP, 1'b0, 1'b1};
      4'hF: d = '{TMR16_TOP_CMPA, TMR16_MAX, TMR16_AT_TOP, TMR16_AT_TOP, 1'b0, 1'b1};
      default: d = d;
    endcase
    return d;
  endfunction

  // Non-PWM output action on a match.
  function automatic logic act(input logic [1:0] sel, input logic cur);
    case (sel)
      TMR16_ACT_TOG: return ~cur;
      TMR16_ACT_CLR: return 1'b0;
      TMR16_ACT_SET: return 1'b1;
      default:       return cur;
    endcase
  endfunction

  // Pins are synchronised, so the external clock works whatever drives the pin.
  tmr16_sync u_cap_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    (capture_pin),
    .level  (cap_lvl),
    .rise   (),
    .fall   ()
  );
  tmr16_sync u_ext_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    (ext_count_pin),
    .level  (),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  // Field decode from the control registers.
  always_comb begin
    wave_mode_sel = {timer_ctrl_b[4:3], timer_ctrl_a[1:0]};
    md            = decode(wave_mode_sel);
    clock_sel     = tmr16_clk_e'(timer_ctrl_b[2:0]);
    case (md.topsrc)
      TMR16_TOP_CMPA: top = compare_value[0];
      TMR16_TOP_CAP:  top = capture_value;
      default:        top = md.fixtop;
    endcase
    at_top    = (count_value == top);
    at_bottom = (count_value == TMR16_BOTTOM);
  end

  // Timer clock enable from prescaler or external edges.
  always_comb begin
    case (clock_sel)
      TMR16_CS_DIV1:    tick = 1'b1;
      TMR16_CS_DIV8:    tick = (presc[2:0] == TMR16_DIV8[2:0]);
      TMR16_CS_DIV64:   tick = (presc[5:0] == TMR16_DIV64[5:0]);
      TMR16_CS_DIV256:  tick = (presc[7:0] == TMR16_DIV256[7:0]);
      TMR16_CS_DIV1024: tick = (presc == TMR16_DIV1024);
      TMR16_CS_EXTF:    tick = ext_fall;
      TMR16_CS_EXTR:    tick = ext_rise;
      default:          tick = 1'b0;
    endcase
  end

  // Noise filter and edge detect on the filtered capture input.
  always_comb begin
    next_filt_out = filt_out;
    next_filt_run = 2'h0;
    if (!timer_ctrl_b[TMR16_B_FILT]) begin
      next_filt_out = cap_lvl;
    end else if (cap_lvl != filt_out) begin
      next_filt_run = filt_run + 2'h1;
      if (filt_run == TMR16_FILT_LAST) begin
        next_filt_out = cap_lvl;
        next_filt_run = 2'h0;
      end
    end
    cap_rise = next_filt_out & ~filt_out;
    cap_fall = ~next_filt_out & filt_out;
    cap_trig = (md.topsrc != TMR16_TOP_CAP) &&
               (timer_ctrl_b[TMR16_B_EDGE] ? cap_rise : cap_fall);
  end

  // Register bus, counter, compare, flags and waveform outputs.
  always_comb begin
    next_ctrl_a  = timer_ctrl_a;
    next_ctrl_b  = timer_ctrl_b;
    next_temp    = temp_hi;
    next_count   = count_value;
    next_capture = capture_value;
    next_cmp     = compare_value;
    next_buf     = compare_buf;
    next_down    = count_down;
    next_block   = block_match;
    next_presc   = (clock_sel == TMR16_CS_STOP) ? presc : presc + 10'h001;
    next_wave    = wave;
    next_ovf     = overflow_flag;
    next_icf     = capture_flag;
    next_cmpf    = compare_flag;
    next_rdata   = rdata_q;
    force_str    = 3'h0;
    // Flag clears by writing one; a set in the same cycle still wins below.
    if (bus.wr && bus.addr == TMR16_IDX_FLAGS) begin
      next_ovf  = overflow_flag & ~bus.wdata[TMR16_B_OVF];
      next_icf  = capture_flag & ~bus.wdata[TMR16_B_ICF];
      next_cmpf = compare_flag & ~bus.wdata[3:1];
    end
    // Compare buffer updates immediately in non-PWM modes.
    if (md.upd_at == TMR16_AT_NOW) next_cmp = compare_buf;
    // Timer tick: match, overflow, reload points, counting.
    if (tick) begin
      next_block = 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (!block_match && count_value == compare_value[i]) begin
          next_cmpf[i] = 1'b1;
          if (!md.pwm) next_wave[i] = act(timer_ctrl_a[7-2*i -: 2], wave[i]);
        end
      end
      if ((md.upd_at == TMR16_AT_TOP && at_top) || (md.upd_at == TMR16_AT_BOTTOM && at_bottom))
        next_cmp = compare_buf;
      if ((md.ovf_at == TMR16_AT_TOP && at_top) || (md.ovf_at == TMR16_AT_BOTTOM && at_bottom && count_down)
          || (md.ovf_at == TMR16_AT_MAX && count_value == TMR16_MAX))
        next_ovf = 1'b1;
      if (md.topsrc == TMR16_TOP_CAP && at_top) next_icf = 1'b1;
      if (md.updown) begin
        if (at_top) next_down = 1'b1;
        else if (at_bottom) next_down = 1'b0;
        next_count = (next_down && !at_bottom) ? count_value - 16'h0001 : count_value + 16'h0001;
      end else begin
        next_down  = 1'b0;
        next_count = (at_top && md.topsrc != TMR16_TOP_FIX) || (at_top && md.pwm)
                     ? TMR16_BOTTOM : count_value + 16'h0001;
      end
    end
    // Capture copies the counter and sets the flag.
    if (cap_trig) begin
      next_capture = count_value;
      next_icf     = 1'b1;
    end
    // Writes; the high byte always lands in the shared temporary.
    if (bus.wr) begin
      case (bus.addr)
        TMR16_IDX_CTRL_A: next_ctrl_a = bus.wdata;
        TMR16_IDX_CTRL_B: next_ctrl_b = bus.wdata & ~(8'h01 << TMR16_B_RSVD);
        TMR16_IDX_CTRL_C: force_str   = bus.wdata[TMR16_B_FOCA -: 3];
        TMR16_IDX_CNT_HI, TMR16_IDX_CAP_HI, TMR16_IDX_CMPA_HI,
        TMR16_IDX_CMPB_HI, TMR16_IDX_CMPC_HI: next_temp = bus.wdata;
        TMR16_IDX_CNT_LO: begin
          next_count = {temp_hi, bus.wdata};
          next_block = 1'b1;
        end
        TMR16_IDX_CAP_LO:  next_capture = {temp_hi, bus.wdata};
        TMR16_IDX_CMPA_LO: next_buf[0]  = {temp_hi, bus.wdata};
        TMR16_IDX_CMPB_LO: next_buf[1]  = {temp_hi, bus.wdata};
        TMR16_IDX_CMPC_LO: next_buf[2]  = {temp_hi, bus.wdata};
        default: next_temp = next_temp;
      endcase
    end
    // Forced match alters only the output, never flags or the counter.
    for (int i = 0; i < 3; i++) begin
      if (force_str[2-i] && !md.pwm) next_wave[i] = act(timer_ctrl_a[7-2*i -: 2], wave[i]);
    end
    // Reads; low byte read parks the high byte in the temporary.
    if (bus.rd) begin
      case (bus.addr)
        TMR16_IDX_CTRL_A:  next_rdata = timer_ctrl_a;
        TMR16_IDX_CTRL_B:  next_rdata = timer_ctrl_b;
        TMR16_IDX_CNT_LO: begin
          next_rdata = count_value[7:0];
          next_temp  = count_value[15:8];
        end
        TMR16_IDX_CAP_LO: begin
          next_rdata = capture_value[7:0];
          next_temp  = capture_value[15:8];
        end
        TMR16_IDX_CMPA_LO: begin
          next_rdata = compare_buf[0][7:0];
          next_temp  = compare_buf[0][15:8];
        end
        TMR16_IDX_CMPB_LO: begin
          next_rdata = compare_buf[1][7:0];
          next_temp  = compare_buf[1][15:8];
        end
        TMR16_IDX_CMPC_LO: begin
          next_rdata = compare_buf[2][7:0];
          next_temp  = compare_buf[2][15:8];
        end
        TMR16_IDX_CNT_HI, TMR16_IDX_CAP_HI, TMR16_IDX_CMPA_HI,
        TMR16_IDX_CMPB_HI, TMR16_IDX_CMPC_HI: next_rdata = temp_hi;
        TMR16_IDX_FLAGS: next_rdata = {2'h0, capture_flag, 1'b0, compare_flag[2],
                                       compare_flag[1], compare_flag[0], overflow_flag};
        default: next_rdata = TMR16_RST_BYTE; // Control C and unmapped read zero.
      endcase
    end
  end

  // State registers; no clock enable, every flop updates each edge.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_ctrl_a  <= TMR16_RST_BYTE;
      timer_ctrl_b  <= TMR16_RST_BYTE;
      temp_hi       <= TMR16_RST_BYTE;
      count_value   <= TMR16_BOTTOM;
      capture_value <= TMR16_BOTTOM;
      compare_value <= '{default: TMR16_BOTTOM};
      compare_buf   <= '{default: TMR16_BOTTOM};
      count_down    <= 1'b0;
      block_match   <= 1'b0;
      presc         <= 10'h000;
      filt_out      <= 1'b0;
      filt_run      <= 2'h0;
      wave          <= 3'h0;
      overflow_flag <= 1'b0;
      capture_flag  <= 1'b0;
      compare_flag  <= 3'h0;
      rdata_q       <= TMR16_RST_BYTE;
      compare_output_en <= 3'h0;
    end else begin
      timer_ctrl_a  <= next_ctrl_a;
      timer_ctrl_b  <= next_ctrl_b;
      temp_hi       <= next_temp;
      count_value   <= next_count;
      capture_value <= next_capture;
      compare_value <= next_cmp;
      compare_buf   <= next_buf;
      count_down    <= next_down;
      block_match   <= next_block;
      presc         <= next_presc;
      filt_out      <= next_filt_out;
      filt_run      <= next_filt_run;
      wave          <= next_wave;
      overflow_flag <= next_ovf;
      capture_flag  <= next_icf;
      compare_flag  <= next_cmpf;
      rdata_q       <= next_rdata;
      compare_output_en <= {|next_ctrl_a[3:2], |next_ctrl_a[5:4], |next_ctrl_a[7:6]};
    end
  end

  assign rdata              = rdata_q;
  assign compare_output_pin = wave;

  // A forced strobe leaves the compare and overflow flags untouched.
  a_force_no_flag: assert property (@(posedge clock) disable iff (!arst_n)
    (bus.wr && bus.addr == TMR16_IDX_CTRL_C && !tick && !cap_trig && !(bus.addr == TMR16_IDX_FLAGS))
    |=> $stable(compare_flag) && $stable(overflow_flag))
    else $error("forced compare changed a flag");

  // Control C always reads zero.
  a_force_read_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (bus.rd && bus.addr == TMR16_IDX_CTRL_C) |=> rdata == 8'h00)
    else $error("force bits did not read zero");

  // Stopped clock holds the counter.
  a_stop_holds: assert property (@(posedge clock) disable iff (!arst_n)
    (clock_sel == TMR16_CS_STOP && !bus.wr) |=> $stable(count_value))
    else $error("counter moved while stopped");

  // Capture copies the counter and flags it.
  a_capture_copy: assert property (@(posedge clock) disable iff (!arst_n)
    (cap_trig && !bus.wr) |=> capture_value == $past(count_value) && capture_flag)
    else $error("capture did not copy counter");

  // While the capture value is TOP, pin edges must leave it untouched.
  a_cap_disconnect: assert property (@(posedge clock) disable iff (!arst_n)
    (md.topsrc == TMR16_TOP_CAP && !bus.wr) |=> $stable(capture_value))
    else $error("capture fired while disconnected");

  // Counter write blocks the next tick's match.
  a_write_blocks: assert property (@(posedge clock) disable iff (!arst_n)
    (bus.wr && bus.addr == TMR16_IDX_CNT_LO) |=> block_match)
    else $error("counter write did not block match");

  // Normal mode wraps from maximum and sets overflow.
  a_normal_ovf: assert property (@(posedge clock) disable iff (!arst_n)
    (wave_mode_sel == 4'h0 && tick && count_value == TMR16_MAX && !bus.wr)
    |=> count_value == TMR16_BOTTOM && overflow_flag)
    else $error("normal mode overflow wrong");

  // Reserved bit of control B reads back zero.
  a_rsvd_zero: assert property (@(posedge clock) disable iff (!arst_n)
    timer_ctrl_b[TMR16_B_RSVD] == 1'b0)
    else $error("reserved bit stored");
endmodule

// ==== tmr16_pin_model.sv ====
// Far-end model of the timer pins: capture input and external count input.
module tmr16_pin_model (
  input  wire logic clock,
  output logic      capture_pin,
  output logic      ext_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both pins rest low until a test drives them.
  initial begin
    capture_pin   = 1'b0;
    ext_count_pin = 1'b0;
  end

  // Software toggling the count pin as a port output still counts.
  // Each level is held for six cycles so that it clears the synchroniser.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (6) @(posedge clock);
      ext_count_pin <= 1'b1;
      repeat (6) @(posedge clock);
      ext_count_pin <= 1'b0;
    end
  endtask

  // Moves the capture pin to a level and holds it for a number of cycles.
  task automatic cap_level(input logic v, input int hold);
    @(posedge clock);
    capture_pin <= v;
    repeat (hold) @(posedge clock);
  endtask
endmodule

// ==== tmr16_pkg.sv ====
// Package with register indices, field positions and mode encodings of the 16-bit timer core.
package tmr16_pkg;

  // Register indices on the processor I/O bus, low address bits.
  localparam logic [3:0] TMR16_IDX_CTRL_A   = 4'h0;
  localparam logic [3:0] TMR16_IDX_CTRL_B   = 4'h1;
  localparam logic [3:0] TMR16_IDX_CTRL_C   = 4'h2;
  localparam logic [3:0] TMR16_IDX_CNT_LO   = 4'h4;
  localparam logic [3:0] TMR16_IDX_CNT_HI   = 4'h5;
  localparam logic [3:0] TMR16_IDX_CAP_LO   = 4'h6;
  localparam logic [3:0] TMR16_IDX_CAP_HI   = 4'h7;
  localparam logic [3:0] TMR16_IDX_CMPA_LO  = 4'h8;
  localparam logic [3:0] TMR16_IDX_CMPA_HI  = 4'h9;
  localparam logic [3:0] TMR16_IDX_CMPB_LO  = 4'hA;
  localparam logic [3:0] TMR16_IDX_CMPB_HI  = 4'hB;
  localparam logic [3:0] TMR16_IDX_CMPC_LO  = 4'hC;
  localparam logic [3:0] TMR16_IDX_CMPC_HI  = 4'hD;
  localparam logic [3:0] TMR16_IDX_FLAGS    = 4'hE;

  // Field positions.
  localparam int TMR16_B_FILT   = 7;
  localparam int TMR16_B_EDGE   = 6;
  localparam int TMR16_B_RSVD   = 5;
  localparam int TMR16_B_FOCA   = 7;
  localparam int TMR16_B_ICF    = 5;
  localparam int TMR16_B_OVF    = 0;

  // Reset values and fixed tops.
  localparam logic [7:0]  TMR16_RST_BYTE = 8'h00;
  localparam logic [15:0] TMR16_MAX      = 16'hFFFF;
  localparam logic [15:0] TMR16_BOTTOM   = 16'h0000;
  localparam logic [15:0] TMR16_TOP8     = 16'h00FF;
  localparam logic [15:0] TMR16_TOP9     = 16'h01FF;
  localparam logic [15:0] TMR16_TOP10    = 16'h03FF;

  // Prescaler taps, as divider minus one.
  localparam logic [9:0] TMR16_DIV8    = 10'h007;
  localparam logic [9:0] TMR16_DIV64   = 10'h03F;
  localparam logic [9:0] TMR16_DIV256  = 10'h0FF;
  localparam logic [9:0] TMR16_DIV1024 = 10'h3FF;

  // Noise filter run length.
  localparam logic [1:0] TMR16_FILT_LAST = 2'h3;

  typedef enum logic [2:0] {
    TMR16_CS_STOP = 3'h0, TMR16_CS_DIV1 = 3'h1, TMR16_CS_DIV8 = 3'h2,
    TMR16_CS_DIV64 = 3'h3, TMR16_CS_DIV256 = 3'h4, TMR16_CS_DIV1024 = 3'h5,
    TMR16_CS_EXTF = 3'h6, TMR16_CS_EXTR = 3'h7
  } tmr16_clk_e;

  typedef enum logic [1:0] {
    TMR16_ACT_OFF = 2'h0, TMR16_ACT_TOG = 2'h1, TMR16_ACT_CLR = 2'h2, TMR16_ACT_SET = 2'h3
  } tmr16_act_e;

  typedef enum logic [1:0] {
    TMR16_TOP_FIX = 2'h0, TMR16_TOP_CMPA = 2'h1, TMR16_TOP_CAP = 2'h2
  } tmr16_topsrc_e;

  typedef enum logic [1:0] {
    TMR16_AT_NOW = 2'h0, TMR16_AT_TOP = 2'h1, TMR16_AT_BOTTOM = 2'h2, TMR16_AT_MAX = 2'h3
  } tmr16_at_e;

  // Decoded waveform mode.
  typedef struct packed {
    tmr16_topsrc_e topsrc;
    logic [15:0]   fixtop;
    tmr16_at_e     upd_at;
    tmr16_at_e     ovf_at;
    logic          updown;
    logic          pwm;
  } tmr16_mode_s;

  // Processor bus request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tmr16_bus_s;

endpackage

// ==== tmr16_sync.sv ====
// Three-stage pin synchroniser with agreement check, shared by both timer pins.
module tmr16_sync
  import tmr16_pkg::*;
(
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // The first stage feeds only the second; a change counts when stages two and three agree.
  always_comb begin
    next_stage = {stage[1:0], pin};
    next_level = (stage[2] == stage[1]) ? stage[2] : level;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level;
  assign fall = ~next_level & level;
endmodule
